/* src/flash_cmd_pkg.sv */
// Shared constants and types for the serial flash command port
package flash_cmd_pkg;

   // ===========================================================
   // Timing
   localparam int CLK_PERIOD_NS  = 10;
   localparam int SCLK_PERIOD_NS = 80;
   localparam int HALF_SCLK_CYCLES = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam logic [2:0] HALF_SCLK_LAST = 3'(HALF_SCLK_CYCLES - 1);

   // ===========================================================
   // Register byte offsets
   localparam logic [7:0] OFF_PAGE_WRITE   = 8'h00;
   localparam logic [7:0] OFF_PAGE_FETCH   = 8'h04;
   localparam logic [7:0] OFF_ERASE_SMALL  = 8'h08;
   localparam logic [7:0] OFF_ERASE_MEDIUM = 8'h0c;
   localparam logic [7:0] OFF_ERASE_LARGE  = 8'h10;
   localparam logic [7:0] OFF_ERASE_ALL    = 8'h14;
   localparam logic [7:0] OFF_ALLOW_WRITES = 8'h18;
   localparam logic [7:0] OFF_BLOCK_WRITES = 8'h1c;
   localparam logic [7:0] OFF_STATE_FETCH  = 8'h20;
   localparam logic [7:0] OFF_STATE_STORE  = 8'h24;
   localparam logic [7:0] OFF_SLEEP        = 8'h28;
   localparam logic [7:0] OFF_WAKE         = 8'h2c;
   localparam logic [7:0] OFF_MAKER_FETCH  = 8'h30;
   localparam logic [7:0] OFF_USER_LOW     = 8'h34;
   localparam logic [7:0] OFF_USER_HIGH    = 8'h38;
   localparam logic [7:0] OFF_USER_COUNT   = 8'h3c;
   localparam logic [7:0] OFF_REPLY_COUNT  = 8'h40;
   localparam logic [7:0] OFF_REPLY_WORD   = 8'h44;
   localparam logic [7:0] OFF_USER_GO      = 8'h48;
   localparam logic [7:0] OFF_WRITE_SIZE   = 8'h4c;
   localparam logic [7:0] OFF_FETCH_SIZE   = 8'h50;
   localparam logic [7:0] OFF_BUSY         = 8'h54;
   localparam logic [7:0] OFF_PROG_BUF     = 8'h58;
   localparam logic [7:0] OFF_READ_BUF     = 8'h5c;

   // ===========================================================
   // Flash opcodes, defaults only
   localparam logic [7:0] OP_PAGE_WRITE   = 8'h02;
   localparam logic [7:0] OP_PAGE_FETCH   = 8'h03;
   localparam logic [7:0] OP_ERASE_SMALL  = 8'h20;
   localparam logic [7:0] OP_ERASE_MEDIUM = 8'h52;
   localparam logic [7:0] OP_ERASE_LARGE  = 8'hd8;
   localparam logic [7:0] OP_ERASE_ALL    = 8'hc7;
   localparam logic [7:0] OP_ALLOW_WRITES = 8'h06;
   localparam logic [7:0] OP_BLOCK_WRITES = 8'h04;
   localparam logic [7:0] OP_STATE_FETCH  = 8'h05;
   localparam logic [7:0] OP_STATE_STORE  = 8'h01;
   localparam logic [7:0] OP_SLEEP        = 8'hb9;
   localparam logic [7:0] OP_WAKE         = 8'hab;
   localparam logic [7:0] OP_MAKER_FETCH  = 8'h9f;

   // ===========================================================
   // Counts and reset values
   localparam logic [8:0] MAKER_REPLY_BYTES = 9'h003;
   localparam logic [8:0] PAGE_SIZE_RESET   = 9'h100;
   localparam logic [3:0] ADDR_CMD_BYTES    = 4'h4;
   localparam logic [3:0] USER_MAX_BYTES    = 4'h8;
   localparam logic [1:0] RESP_OKAY         = 2'b00;
   localparam logic [1:0] RESP_SLVERR       = 2'b10;

   // ===========================================================
   // Types
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SEND = 4'b0010,
      ST_WAIT = 4'b0100,
      ST_END  = 4'b1000
   } seq_state_type;

   typedef enum logic [4:0] {
      K_PLAIN = 5'b00001,
      K_PROG  = 5'b00010,
      K_STATE = 5'b00100,
      K_MAKER = 5'b01000,
      K_USER  = 5'b10000
   } result_kind_type;

endpackage

/* src/spi_byte_shifter.sv */
// One-byte serial shifter with clock divider and input synchroniser
module spi_byte_shifter
   import flash_cmd_pkg::*;
(
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Byte request
   input  wire logic       start,
   input  wire logic [7:0] tx_byte,
   output logic            done,
   output logic [7:0]      rx_byte,
   // Serial pins
   input  wire logic       miso,
   output logic            sclk,
   output logic            mosi
);

   logic       active;
   logic [2:0] phase_cnt;
   logic [2:0] bit_cnt;
   logic [7:0] tx_shift;
   logic       miso_meta;
   logic       miso_sync;

   // ===========================================================
   // Input synchroniser
   always_ff @(posedge aclk)
   begin
      miso_meta <= miso;
      miso_sync <= miso_meta;
   end

   // Sampling two cycles late is safe: the flash changed its data
   // half a serial period before the rising edge
   assign mosi = tx_shift[7];

   // ===========================================================
   // Shift engine, mode 0, most significant bit first
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         active    <= 1'b0;
         phase_cnt <= 3'h0;
         bit_cnt   <= 3'h0;
         tx_shift  <= 8'h00;
         rx_byte   <= 8'h00;
         sclk      <= 1'b0;
         done      <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (!active)
         begin
            if (start)
            begin
               active    <= 1'b1;
               tx_shift  <= tx_byte;
               phase_cnt <= 3'h0;
               bit_cnt   <= 3'h7;
            end
         end
         else if (phase_cnt != HALF_SCLK_LAST)
            phase_cnt <= phase_cnt + 3'h1;
         else
         begin
            phase_cnt <= 3'h0;
            sclk      <= !sclk;
            if (!sclk)
               rx_byte <= {rx_byte[6:0], miso_sync};
            else if (bit_cnt == 3'h0)
            begin
               active <= 1'b0;
               done   <= 1'b1;
            end
            else
            begin
               bit_cnt  <= bit_cnt - 3'h1;
               tx_shift <= {tx_shift[6:0], 1'b0};
            end
         end
      end
   end

endmodule // spi_byte_shifter

/* src/spi_flash_command_port.sv */
// Flash command sequencer behind an AXI4-Lite register slave
// What this block does
// - Page program trigger sends address plus buffer
// - Page read trigger starts read at address
// - First erase trigger clears 4 KB sector
// - Second erase trigger clears 32 KB region
// - Third erase trigger clears 64 KB region
// - Chip erase trigger sends whole-array erase
// - Write enable/disable, sleep, wake send opcodes
// - Status read returns one flash status byte
// - Status write sends opcode then software byte
// - Identification trigger returns flash maker code
// - Lower user word held, sent last, MSB first
// - User words shift out most significant first
// - Upper user word extends long commands
// - Send exactly the programmed command byte count
// - Receive reply count bytes, zero means none
// - First four received reply bytes readable from reply word
// - First reply byte lands in top byte
// - User command starts only on go write
// - Page sizes come from size registers
module spi_flash_command_port
   import flash_cmd_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Write address channel
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   // Write data channel
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // Write response channel
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // Read address channel
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   // Read data channel
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Serial flash pins
   output logic             sclk,
   output logic             cs_n,
   output logic             mosi,
   input  wire logic        miso
);
   import flash_cmd_pkg::*;

   // ===========================================================
   // Functions
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            res[8*i +: 8] = data[8*i +: 8];
      return res;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return (a[1:0] == 2'b00) && (a <= OFF_READ_BUF);
   endfunction

   // ===========================================================
   // Declarations
   logic            aw_hold;
   logic            w_hold;
   logic [7:0]      wr_addr;
   logic [31:0]     wr_data;
   logic [3:0]      wr_strb;
   seq_state_type   state;
   result_kind_type kind;
   result_kind_type next_kind;
   logic [63:0]     tx_word;
   logic [63:0]     next_tx_word;
   logic [3:0]      tx_left;
   logic [3:0]      next_tx_len;
   logic [8:0]      prog_left;
   logic [8:0]      next_prog_len;
   logic [8:0]      rx_left;
   logic [8:0]      next_rx_len;
   logic [8:0]      rx_idx;
   logic [7:0]      prog_idx;
   logic [7:0]      prog_wr_ptr;
   logic [7:0]      rd_ptr;
   logic [31:0]     rx_word;
   logic            launch_ok;
   logic [31:0]     user_low;
   logic [31:0]     user_high;
   logic [3:0]      user_count;
   logic [7:0]      reply_count;
   logic [31:0]     reply_word;
   logic [7:0]      status_byte;
   logic [31:0]     maker_word;
   logic [8:0]      write_size;
   logic [8:0]      fetch_size;
   logic [7:0]      prog_mem [256];
   logic [7:0]      read_mem [256];
   logic            shift_done;
   logic [7:0]      shift_rx;

   // ===========================================================
   // Bus decode
   wire         wr_fire  = aw_hold && w_hold && !bvalid;
   wire         rd_fire  = arvalid && arready;
   wire         idle     = (state == ST_IDLE);
   wire         launch   = wr_fire && launch_ok && idle;
   wire         in_tx    = (tx_left != 4'h0);
   wire         in_prog  = !in_tx && (prog_left != 9'h000);
   wire         in_rx    = !in_tx && !in_prog;
   wire         more     = in_tx ? (tx_left > 4'h1 || prog_left != 9'h000
                                    || rx_left != 9'h000)
                         : in_prog ? (prog_left > 9'h001
                                      || rx_left != 9'h000)
                         : (rx_left > 9'h001);
   wire [7:0]   send_byte = in_tx ? tx_word[63:56]
                          : in_prog ? prog_mem[prog_idx] : 8'h00;
   wire [31:0]  wr_merged = merge(32'h0, wr_data, wr_strb);
   wire         user_ok  = (user_count != 4'h0)
                           && (user_count <= USER_MAX_BYTES);
   wire [3:0]   hi_bytes = user_count - ADDR_CMD_BYTES;
   wire [8:0]   hi_shift = {2'b00, hi_bytes, 3'b000};
   wire [31:0]  hi_mask  = ~(32'hffffffff >> hi_shift);
   wire [63:0]  user_tx  = (user_count > ADDR_CMD_BYTES)
                           ? ({user_high & hi_mask, 32'h0}
                              | ({user_low, 32'h0} >> hi_shift))
                           : {user_low, 32'h0};
   wire [31:0]  rx_place = {shift_rx, 24'h0} >> {rx_idx[1:0], 3'b000};
   wire [31:0]  rd_mux   =
        (araddr == OFF_STATE_FETCH) ? {24'h0, status_byte}
      : (araddr == OFF_MAKER_FETCH) ? maker_word
      : (araddr == OFF_USER_LOW)    ? user_low
      : (araddr == OFF_USER_HIGH)   ? user_high
      : (araddr == OFF_USER_COUNT)  ? {28'h0, user_count}
      : (araddr == OFF_REPLY_COUNT) ? {24'h0, reply_count}
      : (araddr == OFF_REPLY_WORD)  ? reply_word
      : (araddr == OFF_WRITE_SIZE)  ? {23'h0, write_size}
      : (araddr == OFF_FETCH_SIZE)  ? {23'h0, fetch_size}
      : (araddr == OFF_BUSY)        ? {31'h0, !idle}
      : (araddr == OFF_READ_BUF)    ? {24'h0, read_mem[rd_ptr]}
      : 32'h0;

   assign awready = !aw_hold;
   assign wready  = !w_hold;
   assign arready = !rvalid;

   // ===========================================================
   // Command builder
   always_comb
   begin
      next_tx_word  = {wr_data[7:0], 56'h0};
      next_tx_len   = 4'h1;
      next_prog_len = 9'h000;
      next_rx_len   = 9'h000;
      next_kind     = K_PLAIN;
      launch_ok     = 1'b1;
      case (wr_addr)
         OFF_PAGE_WRITE:
         begin
            next_tx_word  = {OP_PAGE_WRITE, wr_data[23:0], 32'h0};
            next_tx_len   = ADDR_CMD_BYTES;
            next_prog_len = write_size;
            next_kind     = K_PROG;
         end
         OFF_PAGE_FETCH:
         begin
            next_tx_word = {OP_PAGE_FETCH, wr_data[23:0], 32'h0};
            next_tx_len  = ADDR_CMD_BYTES;
            next_rx_len  = fetch_size;
         end
         OFF_ERASE_SMALL:
         begin
            next_tx_word = {OP_ERASE_SMALL, wr_data[23:0], 32'h0};
            next_tx_len  = ADDR_CMD_BYTES;
         end
         OFF_ERASE_MEDIUM:
         begin
            next_tx_word = {OP_ERASE_MEDIUM, wr_data[23:0], 32'h0};
            next_tx_len  = ADDR_CMD_BYTES;
         end
         OFF_ERASE_LARGE:
         begin
            next_tx_word = {OP_ERASE_LARGE, wr_data[23:0], 32'h0};
            next_tx_len  = ADDR_CMD_BYTES;
         end
         OFF_ERASE_ALL:    next_tx_word = {OP_ERASE_ALL, 56'h0};
         OFF_ALLOW_WRITES: next_tx_word = {OP_ALLOW_WRITES, 56'h0};
         OFF_BLOCK_WRITES: next_tx_word = {OP_BLOCK_WRITES, 56'h0};
         OFF_SLEEP:        next_tx_word = {OP_SLEEP, 56'h0};
         OFF_WAKE:         next_tx_word = {OP_WAKE, 56'h0};
         OFF_STATE_FETCH:
         begin
            next_tx_word = {OP_STATE_FETCH, 56'h0};
            next_rx_len  = 9'h001;
            next_kind    = K_STATE;
         end
         OFF_STATE_STORE:
         begin
            next_tx_word = {OP_STATE_STORE, wr_data[7:0], 48'h0};
            next_tx_len  = 4'h2;
         end
         OFF_MAKER_FETCH:
         begin
            next_tx_word = {OP_MAKER_FETCH, 56'h0};
            next_rx_len  = MAKER_REPLY_BYTES;
            next_kind    = K_MAKER;
         end
         OFF_USER_GO:
         begin
            next_tx_word = user_tx;
            next_tx_len  = user_count;
            next_rx_len  = {1'b0, reply_count};
            next_kind    = K_USER;
            launch_ok    = user_ok;
         end
         default: launch_ok = 1'b0;
      endcase
   end

   // ===========================================================
   // AXI4-Lite slave
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold <= 1'b0;
         w_hold  <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 32'h0;
         wr_strb <= 4'h0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
         rvalid  <= 1'b0;
         rresp   <= RESP_OKAY;
         rdata   <= 32'h0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_hold <= 1'b1;
            wr_addr <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_hold  <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (wr_fire)
         begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bready)
            bvalid <= 1'b0;
         if (rd_fire)
         begin
            rvalid <= 1'b1;
            rdata  <= rd_mux;
            rresp  <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (rready)
            rvalid <= 1'b0;
      end
   end

   // ===========================================================
   // Configuration registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         user_low    <= 32'h0;
         user_high   <= 32'h0;
         user_count  <= 4'h0;
         reply_count <= 8'h00;
         write_size  <= PAGE_SIZE_RESET;
         fetch_size  <= PAGE_SIZE_RESET;
      end
      else if (wr_fire)
      begin
         if (wr_addr == OFF_USER_LOW)
            user_low <= merge(user_low, wr_data, wr_strb);
         if (wr_addr == OFF_USER_HIGH)
            user_high <= merge(user_high, wr_data, wr_strb);
         if (wr_addr == OFF_USER_COUNT)
            user_count <= wr_merged[3:0];
         if (wr_addr == OFF_REPLY_COUNT)
            reply_count <= wr_merged[7:0];
         if (wr_addr == OFF_WRITE_SIZE)
            write_size <= wr_merged[8:0];
         if (wr_addr == OFF_FETCH_SIZE)
            fetch_size <= wr_merged[8:0];
      end
   end

   // ===========================================================
   // Page buffers, no reset on the arrays
   always_ff @(posedge aclk)
   begin
      if (wr_fire && wr_addr == OFF_PROG_BUF)
         prog_mem[prog_wr_ptr] <= wr_data[7:0];
      if (state == ST_WAIT && shift_done && in_rx)
         read_mem[rx_idx[7:0]] <= shift_rx;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prog_wr_ptr <= 8'h00;
         rd_ptr      <= 8'h00;
      end
      else
      begin
         if (state == ST_END && kind == K_PROG)
            prog_wr_ptr <= 8'h00;
         else if (wr_fire && wr_addr == OFF_PROG_BUF)
            prog_wr_ptr <= prog_wr_ptr + 8'h01;
         if (launch && wr_addr == OFF_PAGE_FETCH)
            rd_ptr <= 8'h00;
         else if (rd_fire && araddr == OFF_READ_BUF)
            rd_ptr <= rd_ptr + 8'h01;
      end
   end

   // ===========================================================
   // Command sequencer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state     <= ST_IDLE;
         kind      <= K_PLAIN;
         cs_n      <= 1'b1;
         tx_word   <= 64'h0;
         tx_left   <= 4'h0;
         prog_left <= 9'h000;
         rx_left   <= 9'h000;
         rx_idx    <= 9'h000;
         prog_idx  <= 8'h00;
         rx_word   <= 32'h0;
      end
      else
      begin
         case (state)
            ST_IDLE:
               if (launch)
               begin
                  state     <= ST_SEND;
                  kind      <= next_kind;
                  cs_n      <= 1'b0;
                  tx_word   <= next_tx_word;
                  tx_left   <= next_tx_len;
                  prog_left <= next_prog_len;
                  rx_left   <= next_rx_len;
                  rx_idx    <= 9'h000;
                  prog_idx  <= 8'h00;
                  rx_word   <= 32'h0;
               end
            ST_SEND: state <= ST_WAIT;
            ST_WAIT:
               if (shift_done)
               begin
                  state <= more ? ST_SEND : ST_END;
                  if (in_tx)
                  begin
                     tx_word <= {tx_word[55:0], 8'h00};
                     tx_left <= tx_left - 4'h1;
                  end
                  else if (in_prog)
                  begin
                     prog_left <= prog_left - 9'h001;
                     prog_idx  <= prog_idx + 8'h01;
                  end
                  else
                  begin
                     rx_left <= rx_left - 9'h001;
                     rx_idx  <= rx_idx + 9'h001;
                     if (rx_idx < 9'h004)
                        rx_word <= rx_word | rx_place;
                  end
               end
            ST_END:
            begin
               state <= ST_IDLE;
               cs_n  <= 1'b1;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ===========================================================
   // Results
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         status_byte <= 8'h00;
         maker_word  <= 32'h0;
         reply_word  <= 32'h0;
      end
      else if (state == ST_END)
      begin
         if (kind == K_STATE)
            status_byte <= rx_word[31:24];
         if (kind == K_MAKER)
            maker_word <= rx_word;
         if (kind == K_USER)
            reply_word <= rx_word;
      end
   end

   // ===========================================================
   // Serial engine
   spi_byte_shifter shifter
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (state == ST_SEND),
      .tx_byte (send_byte),
      .done    (shift_done),
      .rx_byte (shift_rx),
      .miso    (miso),
      .sclk    (sclk),
      .mosi    (mosi)
   );

endmodule // spi_flash_command_port

/* testbench/spi_flash_command_port_properties.sv */
// Bus and serial timing checker for the flash command port
module flash_port_checker
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   // Serial pins
   input wire logic        sclk,
   input wire logic        cs_n,
   input wire logic        mosi
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // Serial link
   sequence high_phase;
      sclk [*4] ##1 !sclk;
   endsequence
   a_sclk_idle: assert property (cs_n |-> !sclk)
      else $error("serial clock moved outside a frame");
   a_sclk_high: assert property ($rose(sclk) |-> high_phase)
      else $error("serial clock high phase wrong");
   a_sclk_low: assert property ($fell(sclk) |-> (!sclk) [*4])
      else $error("serial clock low phase too short");
   a_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
      else $error("serial out moved while clock high");
   a_go_commit: assert property ($fell(cs_n) |-> ##[0:1] $rose(bvalid))
      else $error("frame began without a register write");
   // ==========================================================
   // Register bus
   a_write_answer: assert property (awvalid && awready && wvalid && wready
      |-> ##[1:3] bvalid)
      else $error("write response missing");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   a_read_hold: assert property (rvalid && !rready
      |=> rvalid && $stable(rdata))
      else $error("read data dropped before taken");
   a_read_close: assert property (rvalid && rready |=> !rvalid)
      else $error("read data not released");
endmodule // flash_port_checker

bind spi_flash_command_port flash_port_checker chk_u (.*);

/* testbench/flash_model.sv */
// Serial flash stand-in: records bytes, answers a byte pattern
module flash_model
(
   // Serial pins
   input  wire logic sclk,
   input  wire logic cs_n,
   input  wire logic mosi,
   output logic      miso
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rx[$];
   logic [7:0] sh;
   int         nb;
   // Reply byte k of a frame is 8'h30 + k, MSB first
   function automatic logic rbit(int b);
      logic [7:0] v;
      v = 8'h30 + 8'(b / 8);
      return v[7 - b % 8];
   endfunction
   initial miso = 1'b1;
   always @(negedge cs_n)
   begin
      nb = 0;
      miso = rbit(0);
   end
   // Mode 0: capture on rise, launch on fall
   always @(posedge sclk)
   begin
      sh = {sh[6:0], mosi};
      nb++;
      if (nb % 8 == 0) rx.push_back(sh);
   end
   always @(negedge sclk) miso = rbit(nb);
   // Released line shows the inverse, never a stale copy
   always @(posedge cs_n) miso = ~miso;
endmodule // flash_model

/* testbench/tb_spi_flash_command_port.sv */
// Self-checking bench for the flash command port
module tb_spi_flash_command_port import flash_cmd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] AD = 32'hfffedcba;
   localparam logic [55:0] AT = 56'hfedcba_00000000;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, miso;
   logic awready, wready, bvalid, arready, rvalid, sclk, cs_n, mosi;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [3:0]  wstrb;
   logic [2:0]  h;
   logic [1:0]  bresp, rresp, r;
   int          error_cnt, num_checks, i;
   spi_flash_command_port dut_u (.*);
   flash_model fm (.*);
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // ==========================================================
   // Checking and closing
   task chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("wrong value at %0t: %h expected %h", $time, s, e);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task hang;
      error_cnt++;
      end_of_test;
   endtask
   // ==========================================================
   // Bus cycles, sampled at the falling edge to avoid races
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      repeat (99)
      begin
         @(negedge aclk);
         h = {awvalid & awready, wvalid & wready, bvalid};
         r = bresp;
         @(posedge aclk);
         if (h[2]) awvalid <= 1'b0;
         if (h[1]) wvalid <= 1'b0;
         if (h[0])
         begin
            bready <= 1'b0;
            return;
         end
      end
      hang;
   endtask
   task rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      repeat (99)
      begin
         @(negedge aclk);
         h = {arvalid & arready, rvalid, rvalid & rready};
         v = rdata;
         r = rresp;
         @(posedge aclk);
         if (h[2]) arvalid <= 1'b0;
         if (h[0])
         begin
            rready <= 1'b0;
            return;
         end
      end
      hang;
   endtask
   task idle;
      repeat (2000)
      begin
         @(negedge aclk);
         if (cs_n === 1'b1)
         begin
            repeat (2) @(posedge aclk);
            return;
         end
      end
      hang;
   endtask
   // Trigger, wait for the frame, compare every byte on the wire
   task send(input logic [7:0] a, input logic [7:0] op,
             input logic [31:0] d, input int n, input logic [55:0] t);
      fm.rx.delete();
      wr(a, d);
      idle;
      chk(32'(fm.rx.size()), 32'(n));
      for (i = 0; i < n; i++)
         chk({24'h0, fm.rx[i]}, 32'({op, t} >> (56 - 8 * i)) & 32'hff);
      $display("command at %h done", a);
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      send(OFF_ERASE_SMALL, OP_ERASE_SMALL, AD, 4, AT);
      send(OFF_ERASE_MEDIUM, OP_ERASE_MEDIUM, AD, 4, AT);
      send(OFF_ERASE_LARGE, OP_ERASE_LARGE, AD, 4, AT);
      send(OFF_ERASE_ALL, OP_ERASE_ALL, 0, 1, 0);
      send(OFF_ALLOW_WRITES, OP_ALLOW_WRITES, 0, 1, 0);
      send(OFF_BLOCK_WRITES, OP_BLOCK_WRITES, 0, 1, 0);
      send(OFF_WAKE, OP_WAKE, 0, 1, 0);
      wr(OFF_ALLOW_WRITES, 0);
      send(OFF_SLEEP, OP_ALLOW_WRITES, 0, 1, 0);
      send(OFF_SLEEP, OP_SLEEP, 0, 1, 0);
      send(OFF_STATE_FETCH, OP_STATE_FETCH, 0, 2, 0);
      rd(OFF_STATE_FETCH);
      chk(v, 32'h31);
      send(OFF_STATE_STORE, OP_STATE_STORE, 32'h1a2, 2, 56'ha2 << 48);
      send(OFF_MAKER_FETCH, OP_MAKER_FETCH, 0, 4, 0);
      rd(OFF_MAKER_FETCH);
      chk({v[31:8], 8'h0}, 32'h31323300);
      wr(OFF_WRITE_SIZE, 2);
      wr(OFF_PROG_BUF, 8'hc5);
      wr(OFF_PROG_BUF, 8'h3c);
      send(OFF_PAGE_WRITE, OP_PAGE_WRITE, AD, 6, AT | 56'hc53c0000);
      wr(OFF_FETCH_SIZE, 2);
      send(OFF_PAGE_FETCH, OP_PAGE_FETCH, AD, 6, AT);
      rd(OFF_READ_BUF);
      chk(v, 32'h34);
      rd(OFF_READ_BUF);
      chk(v, 32'h35);
      wr(OFF_USER_LOW, 32'h12345678);
      wr(OFF_USER_HIGH, 32'h9abcdef0);
      wr(OFF_USER_COUNT, 6);
      wr(OFF_REPLY_COUNT, 2);
      send(OFF_USER_GO, 8'h9a, 0, 8, 56'hbc_12345678_0000);
      rd(OFF_REPLY_WORD);
      chk({v[31:16], 16'h0}, 32'h36370000);
      wr(OFF_USER_COUNT, 8);
      wr(OFF_REPLY_COUNT, 0);
      send(OFF_USER_GO, 8'h9a, 0, 8, 56'hbcdef0_12345678);
      wr(OFF_USER_COUNT, 9);
      send(OFF_USER_GO, 0, 0, 0, 0);
      rd(8'h60);
      chk({r, v[29:0]}, {RESP_SLVERR, 30'h0});
      wr(8'h60, 0);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      end_of_test;
   end
endmodule // tb_spi_flash_command_port
